// ---- pkg/ptm_defines.svh ----
/*
 period timer constants: register offsets, field positions, reset values and the timing count.
 assumes byte-wide registers on a plain strobe port; included by bare name.
*/
`ifndef PTM_DEFINES_SVH
`define PTM_DEFINES_SVH

// register offsets
`define PTM_ADDR_COUNT     4'h0
`define PTM_ADDR_CONTROL   4'h1
`define PTM_ADDR_PERIOD    4'h2
`define PTM_ADDR_FLAG      4'h3
`define PTM_ADDR_ENABLE    4'h4
`define PTM_ADDR_PRIORITY  4'h5
`define PTM_ADDR_CLEAR     4'h6

// control field positions and the interrupt bit
`define PTM_POST_HI        6
`define PTM_POST_LO        3
`define PTM_ON_BIT         2
`define PTM_PRE_HI         1
`define PTM_PRE_LO         0
`define PTM_IRQ_BIT        3

// reset values
`define PTM_PERIOD_RST     8'hff
`define PTM_CONTROL_RST    7'h00
`define PTM_COUNT_RST      8'h00

// prescaler terminal counts; the tick lands when the prescaler reaches these
`define PTM_PRE_LAST_DIV1  4'h0
`define PTM_PRE_LAST_DIV4  4'h3
`define PTM_PRE_LAST_DIV16 4'hf

// instruction clock is one quarter of the oscillator
`define PTM_OSC_PER_INSTR  4
`define PTM_INSTR_CYCLES   (`PTM_OSC_PER_INSTR / 4)

`endif

// ---- pkg/ptm_pkg.sv ----
/*
 period timer types: prescale selections and the bus answer type.
 assumes the defines header is compiled alongside.
*/
package ptm_pkg;
	typedef enum logic [1:0] {
		PTM_PRE_DIV1  = 2'b00,
		PTM_PRE_DIV4  = 2'b01,
		PTM_PRE_DIV16 = 2'b10,
		PTM_PRE_DIV16B = 2'b11
	} ptm_pre_t;

	typedef logic [7:0] ptm_byte_t;
	typedef logic [3:0] ptm_addr_t;
endpackage

// ---- core/ptm_timer.sv ----
/*
 8-bit period timer with prescaler, postscaler and match interrupt.
 assumes clk_in is the instruction clock and a synchronous bus master on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none
`include "ptm_defines.svh"

module ptm_timer (
	input  wire logic               clk_in,
	input  wire logic               nrst_in,
	input  wire ptm_pkg::ptm_addr_t addr_in,
	input  wire ptm_pkg::ptm_byte_t wdata_in,
	input  wire logic               wr_in,
	input  wire logic               rd_in,
	output logic [7:0]              rdata_out,
	output logic                    pwm_match_out,
	output logic                    irq_out,
	output logic                    irq_high_prio_out
);
	import ptm_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// registers
	logic [7:0] count_value_reg;
	logic [7:0] period_value_reg;
	logic [6:0] timer_control_reg;
	logic       match_irq_flag_reg;
	logic       match_irq_enable_reg;
	logic       match_irq_priority_reg;
	logic [3:0] pre_cnt_reg;
	logic [3:0] post_cnt_reg;
	logic       timer_on;
	logic [3:0] post_sel;
	ptm_pre_t   pre_sel;
	logic       wr_count;
	logic       wr_control;
	logic       wr_period;
	logic       wr_enable;
	logic       wr_priority;
	logic       wr_clear;
	logic       tick;
	logic       match_hit;
	logic       post_fire;

	// decoded write strobes
	assign wr_count   = wr_in && (addr_in == `PTM_ADDR_COUNT);
	assign wr_control = wr_in && (addr_in == `PTM_ADDR_CONTROL);
	assign wr_period   = wr_in && (addr_in == `PTM_ADDR_PERIOD);
	assign wr_enable   = wr_in && (addr_in == `PTM_ADDR_ENABLE);
	assign wr_priority = wr_in && (addr_in == `PTM_ADDR_PRIORITY);
	assign wr_clear    = wr_in && (addr_in == `PTM_ADDR_CLEAR) && wdata_in[`PTM_IRQ_BIT];

	// control fields
	// codes 10 and 11 of the prescale field both divide by sixteen
	assign timer_on = timer_control_reg[`PTM_ON_BIT];
	assign post_sel = timer_control_reg[`PTM_POST_HI:`PTM_POST_LO];
	assign pre_sel  = ptm_pre_t'(timer_control_reg[`PTM_PRE_HI:`PTM_PRE_LO]);

	// terminal count of the prescaler for a selection
	function automatic logic [3:0] pre_last(input ptm_pre_t sel);
		case (sel)
			PTM_PRE_DIV1:   pre_last = `PTM_PRE_LAST_DIV1;
			PTM_PRE_DIV4:   pre_last = `PTM_PRE_LAST_DIV4;
			default:        pre_last = `PTM_PRE_LAST_DIV16;
		endcase
	endfunction

	// one increment tick per prescale period, only while running; a count or control write in
	// the same cycle swallows the tick, so neither wrap nor increment slips under it
	assign tick      = timer_on && !wr_count && !wr_control && (pre_cnt_reg == pre_last(pre_sel));
	assign match_hit = tick && (count_value_reg == period_value_reg);
	assign post_fire = match_hit && (post_cnt_reg == post_sel);

	////////////////////////////////////////////////////////////////////////
	// control register; bit 7 never stored so it reads zero
	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			timer_control_reg <= `PTM_CONTROL_RST;
		end else if (wr_control) begin
			timer_control_reg <= wdata_in[6:0];
		end
	end

	// period register
	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			period_value_reg <= `PTM_PERIOD_RST;
		end else if (wr_period) begin
			period_value_reg <= wdata_in;
		end
	end

	// prescaler; stopped timer holds it so nothing toggles
	// a tick returns it to zero, so it never runs past the terminal count
	always_ff @(posedge clk_in) begin
		if (!nrst_in || wr_count || wr_control) begin
			pre_cnt_reg <= 4'h0;
		end else if (timer_on) begin
			pre_cnt_reg <= tick ? 4'h0 : pre_cnt_reg + 4'h1;
		end
	end

	// count register; software write wins over an increment
	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			count_value_reg <= `PTM_COUNT_RST;
		end else if (wr_count) begin
			count_value_reg <= wdata_in;
		end else if (match_hit) begin
			count_value_reg <= 8'h00;
		end else if (tick) begin
			count_value_reg <= count_value_reg + 8'h01;
		end
	end

	// postscaler counts matches
	always_ff @(posedge clk_in) begin
		if (!nrst_in || wr_count || wr_control) begin
			post_cnt_reg <= 4'h0;
		end else if (match_hit) begin
			post_cnt_reg <= post_fire ? 4'h0 : post_cnt_reg + 4'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// flag: set beats a same-cycle clear so no event is lost
	// software clears it by writing a one to the flag's bit of the clear register
	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			match_irq_flag_reg <= 1'b0;
		end else if (post_fire) begin
			match_irq_flag_reg <= 1'b1;
		end else if (wr_clear) begin
			match_irq_flag_reg <= 1'b0;
		end
	end

	// enable and priority bits at the flag's position
	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			match_irq_enable_reg   <= 1'b0;
			match_irq_priority_reg <= 1'b0;
		end else begin
			if (wr_enable)
				match_irq_enable_reg <= wdata_in[`PTM_IRQ_BIT];
			if (wr_priority)
				match_irq_priority_reg <= wdata_in[`PTM_IRQ_BIT];
		end
	end

	// registered outputs; irq follows the flag one cycle later
	// irq_out is any enabled flag; the high-priority level adds the priority bit
	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			irq_out           <= 1'b0;
			irq_high_prio_out <= 1'b0;
			pwm_match_out     <= 1'b0;
		end else begin
			irq_out           <= match_irq_flag_reg && match_irq_enable_reg;
			irq_high_prio_out <= match_irq_flag_reg && match_irq_enable_reg && match_irq_priority_reg;
			pwm_match_out     <= match_hit;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read port, data valid the cycle after the strobe
	// unmapped offsets and the write-only clear register read as zero
	always_ff @(posedge clk_in) begin
		if (!nrst_in || !rd_in) begin
			rdata_out <= 8'h00;
		end else begin
			case (addr_in)
				`PTM_ADDR_COUNT:    rdata_out <= count_value_reg;
				`PTM_ADDR_CONTROL:  rdata_out <= {1'b0, timer_control_reg};
				`PTM_ADDR_PERIOD:   rdata_out <= period_value_reg;
				`PTM_ADDR_FLAG:     rdata_out <= 8'(match_irq_flag_reg) << `PTM_IRQ_BIT;
				`PTM_ADDR_ENABLE:   rdata_out <= 8'(match_irq_enable_reg) << `PTM_IRQ_BIT;
				`PTM_ADDR_PRIORITY: rdata_out <= 8'(match_irq_priority_reg) << `PTM_IRQ_BIT;
				default:            rdata_out <= 8'h00;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	// every check sleeps through reset except the two that watch it on purpose
	wrap_to_zero_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		match_hit && !wr_count |=> count_value_reg == 8'h00)
		else $error("count did not wrap after period match");
	period_reset_a: assert property (@(posedge clk_in)
		!nrst_in |=> period_value_reg == 8'hff)
		else $error("period not all ones after reset");
	count_reset_a: assert property (@(posedge clk_in)
		!nrst_in |=> count_value_reg == 8'h00)
		else $error("count not cleared by reset");
	div4_spacing_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		tick && pre_sel == PTM_PRE_DIV4 |-> pre_cnt_reg == 4'h3)
		else $error("divide by four ticked early");
	post_fire_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		post_fire |=> match_irq_flag_reg)
		else $error("postscaled match did not set flag");
	scaler_clear_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		wr_count || wr_control |=> pre_cnt_reg == 4'h0 && post_cnt_reg == 4'h0)
		else $error("scalers not cleared by write");
	ctrl_keeps_count_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		wr_control |=> $stable(count_value_reg))
		else $error("control write changed count");
	off_holds_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		!timer_on && !wr_count |=> $stable(count_value_reg))
		else $error("stopped timer moved");
	irq_level_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		match_irq_flag_reg && match_irq_enable_reg |=> irq_out)
		else $error("enabled flag gave no interrupt");
	pwm_pulse_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		match_hit |=> pwm_match_out)
		else $error("match pulse not sent to pwm");
	top_bit_zero_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		rd_in && addr_in == `PTM_ADDR_CONTROL |=> !rdata_out[7])
		else $error("control top bit read as one");

	// prescaler checks: steps by one, divide by one and divide by sixteen end on their own terminal counts
	prescale_step_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		timer_on && !tick && !wr_count && !wr_control |=> pre_cnt_reg == $past(pre_cnt_reg) + 4'h1)
		else $error("prescaler skipped a step");
	div1_every_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		timer_on && pre_sel == PTM_PRE_DIV1 && !wr_count && !wr_control |-> tick)
		else $error("divide by one missed a tick");
	div16_last_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		tick && pre_sel[1] |-> pre_cnt_reg == 4'hf)
		else $error("divide by sixteen ticked early");
	off_prescale_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		!timer_on && !wr_count && !wr_control |=> $stable(pre_cnt_reg))
		else $error("stopped prescaler moved");

	// count, period, control and postscaler checks
	count_step_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		tick && !match_hit |=> count_value_reg == $past(count_value_reg) + 8'h01)
		else $error("count did not step by one");
	count_write_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		wr_count |=> count_value_reg == $past(wdata_in))
		else $error("count write not taken");
	period_write_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		wr_period |=> period_value_reg == $past(wdata_in))
		else $error("period write not taken");
	control_write_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		wr_control |=> timer_control_reg == $past(wdata_in[6:0]))
		else $error("control write not taken");
	post_bound_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		!(post_cnt_reg > post_sel))
		else $error("postscaler ran past its selection");

	// interrupt checks: sticky flag, clear and both levels; then the quiet pwm pulse
	flag_sticky_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		match_irq_flag_reg && !wr_clear |=> match_irq_flag_reg)
		else $error("flag dropped without a clear");
	flag_clear_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		wr_clear && !post_fire |=> !match_irq_flag_reg)
		else $error("flag survived a clear");
	irq_off_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		!(match_irq_flag_reg && match_irq_enable_reg) |=> !irq_out)
		else $error("interrupt without an enabled flag");
	prio_level_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		match_irq_flag_reg && match_irq_enable_reg && match_irq_priority_reg |=> irq_high_prio_out)
		else $error("high priority level missing");
	prio_low_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		!match_irq_priority_reg |=> !irq_high_prio_out)
		else $error("high priority level without priority bit");
	pwm_quiet_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		!match_hit |=> !pwm_match_out)
		else $error("match pulse without a match");

	// read port checks
	read_idle_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		!rd_in |=> rdata_out == 8'h00)
		else $error("read data without a read");
	read_count_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		rd_in && addr_in == `PTM_ADDR_COUNT |=> rdata_out == $past(count_value_reg))
		else $error("count read back wrong");
	read_period_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		rd_in && addr_in == `PTM_ADDR_PERIOD |=> rdata_out == $past(period_value_reg))
		else $error("period read back wrong");

	wrap_seen_c: cover property (@(posedge clk_in) disable iff (!nrst_in) match_hit);
	flag_seen_c: cover property (@(posedge clk_in) disable iff (!nrst_in) post_fire && post_sel != 4'h0);
	div16_seen_c: cover property (@(posedge clk_in) disable iff (!nrst_in) tick && pre_sel[1]);
	irq_seen_c: cover property (@(posedge clk_in) disable iff (!nrst_in) irq_out);
	ctrl_run_c: cover property (@(posedge clk_in) disable iff (!nrst_in) wr_control && timer_on);
endmodule

`default_nettype wire

// ---- sim/ptm_pwm_sink.sv ----
/*
 stand-in for the pwm units: counts unscaled match pulses and the cycles between them.
 assumes it shares the timer clock and reset.
*/
`timescale 1ns/1ns
`default_nettype none
module ptm_pwm_sink (
	input  wire logic clk_in,
	input  wire logic nrst_in,
	input  wire logic match_in,
	output var  int   hits_out,
	output var  int   gap_out
);
	int run;
	// pulse taken as a time base only
	always @(posedge clk_in) begin
		run <= run + 1;
		if (!nrst_in) begin
			hits_out <= 0;
			gap_out  <= 0;
			run      <= 0;
		end else if (match_in) begin
			hits_out <= hits_out + 1;
			gap_out  <= run + 1;
			run      <= 0;
		end
	end
endmodule
`default_nettype wire

// ---- sim/ptm_timer_test.sv ----
/*
 self-checking bench for the period timer: registers, prescale, postscale, interrupt.
 assumes the strobe bus of the notes and the pwm stand-in model.
*/
`timescale 1ns/1ns
`default_nettype none
`include "ptm_defines.svh"
module ptm_timer_test;
	import ptm_pkg::*;
	logic      clk = 0, nrst = 0, wr = 0, rd = 0, rd_d = 0, pm, irq, irq_hp;
	ptm_addr_t addr = 4'h0;
	ptm_byte_t wdata = 8'h00, rdata, p;
	int        n_fail = 0, tests_run = 0, cyc = 0, hits, gap, h0, k;
	ptm_byte_t exp_q[$];
	always #50 clk = ~clk;
	ptm_timer dut (.clk_in(clk), .nrst_in(nrst), .addr_in(addr), .wdata_in(wdata), .wr_in(wr),
		.rd_in(rd), .rdata_out(rdata), .pwm_match_out(pm), .irq_out(irq), .irq_high_prio_out(irq_hp));
	ptm_pwm_sink sink (.clk_in(clk), .nrst_in(nrst), .match_in(pm), .hits_out(hits), .gap_out(gap));
	////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// one-cycle strobes, changed just after an edge
	task automatic wreg(input ptm_addr_t a, input ptm_byte_t d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rreg(input ptm_addr_t a, input ptm_byte_t e);
		exp_q.push_back(e);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
	endtask
	////////////////////////////////////////////////////////////////
	// read data only stands the cycle after the strobe, so sample it mid-cycle
	always @(posedge clk) rd_d <= rd;
	always @(negedge clk) if (rd_d) chk("read data", rdata, exp_q.pop_front());
	// hang guard, well above the longest run
	always @(posedge clk) begin
		cyc++;
		if (cyc == 30000) begin
			n_fail++;
			wrap_up();
		end
	end
	////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(86130));
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		rreg(`PTM_ADDR_COUNT, 8'h00);
		rreg(`PTM_ADDR_CONTROL, 8'h00);
		rreg(`PTM_ADDR_PERIOD, 8'hff);
		rreg(4'h7, 8'h00);
		p = 8'($urandom);
		wreg(`PTM_ADDR_PERIOD, p);
		rreg(`PTM_ADDR_PERIOD, p);
		wreg(`PTM_ADDR_COUNT, ~p);
		wreg(`PTM_ADDR_CONTROL, 8'hfb);
		rreg(`PTM_ADDR_COUNT, ~p);
		rreg(`PTM_ADDR_CONTROL, 8'h7b);
		// spacing of matches per prescale code, period 3
		wreg(`PTM_ADDR_PERIOD, 8'h03);
		for (k = 0; k < 4; k++) begin
			wreg(`PTM_ADDR_CONTROL, 8'h04 | k[7:0]);
			h0 = hits;
			repeat (400) if (hits < h0 + 3) @(negedge clk);
			chk("match gap", gap[7:0], k == 0 ? 8'h04 : k == 1 ? 8'h10 : 8'h40);
		end
		// matches per flag, counted from fresh scalers
		wreg(`PTM_ADDR_ENABLE, 8'h08);
		wreg(`PTM_ADDR_PRIORITY, 8'h08);
		for (k = 0; k < 16; k += 5) begin
			wreg(`PTM_ADDR_CONTROL, 8'h00);
			wreg(`PTM_ADDR_CLEAR, 8'h08);
			wreg(`PTM_ADDR_COUNT, 8'h00);
			wreg(`PTM_ADDR_CONTROL, {1'b0, k[3:0], 3'b100});
			h0 = hits;
			repeat (200) if (irq !== 1'b1) @(negedge clk);
			chk("irq raised", {7'h00, irq}, 8'h01);
			chk("matches per flag", 8'(hits - h0), 8'(k + 1));
			chk("high priority irq", {7'h00, irq_hp}, 8'h01);
		end
		rreg(`PTM_ADDR_FLAG, 8'h08);
		// masking and clearing
		wreg(`PTM_ADDR_CONTROL, 8'h00);
		wreg(`PTM_ADDR_ENABLE, 8'h00);
		repeat (2) @(negedge clk);
		chk("masked irq", {7'h00, irq}, 8'h00);
		chk("masked high priority irq", {7'h00, irq_hp}, 8'h00);
		// flag still set: low priority gives the plain level only
		wreg(`PTM_ADDR_PRIORITY, 8'h00);
		wreg(`PTM_ADDR_ENABLE, 8'h08);
		rreg(`PTM_ADDR_ENABLE, 8'h08);
		rreg(`PTM_ADDR_PRIORITY, 8'h00);
		@(negedge clk);
		chk("low priority irq", {6'h00, irq, irq_hp}, 8'h02);
		wreg(`PTM_ADDR_CLEAR, 8'h08);
		rreg(`PTM_ADDR_FLAG, 8'h00);
		@(negedge clk);
		chk("cleared irq", {7'h00, irq}, 8'h00);
		rreg(`PTM_ADDR_CLEAR, 8'h00);
		repeat (3) @(posedge clk);
		wrap_up();
	end
endmodule
`default_nettype wire
